// ---- rtl/bfs_delay_timer.sv ----
// tick-driven delay timer used for power-good and undervoltage delays
`timescale 1ns/100ps
module bfs_delay_timer #(
	parameter logic [bfs_pkg::TMR_W-1:0] LIMIT = 12'h008
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic tick,
	bfs_timer_if.tmr t
);
	logic [bfs_pkg::TMR_W-1:0] cnt_q; // elapsed ticks
	logic done_q;
	wire at_limit = (cnt_q >= LIMIT);
	assign t.done = done_q;
	// ****************************************
	// counting
	// ****************************************
	// ticks are 1 us from the main clock, so the figure does not
	// depend on the switching frequency in use
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= '0;
			done_q <= 1'b0;
		end else if (!t.run) begin // any drop restarts the delay
			cnt_q <= '0;
			done_q <= 1'b0;
		end else if (tick && !at_limit) begin
			cnt_q <= cnt_q + 1'b1;
		end else if (at_limit) begin
			done_q <= 1'b1;
		end
	end
endmodule

// ---- rtl/bfs_pkg.sv ----
// constants and types shared by the fault supervisor files
package bfs_pkg;
	// ****************************************
	// register map (byte addresses on apb)
	// ****************************************
	localparam logic [7:0] ADDR_STATUS = 8'h00; // sticky events, w1c
	localparam logic [7:0] ADDR_MASK = 8'h04; // interrupt enables
	localparam logic [7:0] ADDR_STATE = 8'h08; // live state, read only
	localparam logic [7:0] ADDR_CTRL = 8'h0c; // software control
	localparam int EV_W = 8; // event bits
	localparam logic [EV_W-1:0] MASK_RESET = 8'h00;
	localparam logic [EV_W-1:0] CTRL_RESET = 8'h00;
	// event bit positions
	localparam int EV_BIAS_UNDERVOLTAGE_LOCKOUT = 0;
	localparam int EV_OV = 1;
	localparam int EV_UV = 2;
	localparam int EV_OCL_POS = 3;
	localparam int EV_OCL_NEG = 4;
	localparam int EV_THERM = 5;
	localparam int EV_PG_RISE = 6;
	localparam int EV_PG_FALL = 7;
	// control bit positions
	localparam int CTRL_FORCE_OFF = 0;
	// state register field positions
	localparam int ST_LSB = 0; // 3-bit state code
	localparam int PG_BIT = 4;
	localparam int VID_LSB = 8; // 2-bit voltage id
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ = 125; // clock rate
	localparam int TICK_US = 1; // timer tick period in us
	localparam int TICK_CYC = CLK_MHZ * TICK_US;
	localparam int PG_DELAY_US = 3000; // 3 ms after regulation
	localparam int PG_PROP_US = 1000; // 1 ms rising propagation
	localparam int UV_DELAY_US = 8; // 8 us undervoltage latch delay
	localparam int TMR_W = 12; // timer width, holds 3000
	localparam int DIV_W = 7; // tick divider width
	// ****************************************
	// converter states
	// ****************************************
	typedef enum logic [2:0] {
		S_OFF,
		S_RUN,
		S_THERMAL,
		S_UV_LATCH,
		S_OV_LATCH,
		S_BIAS_UNDERVOLTAGE_LOCKOUT_LATCH
	} bfs_state_t;
endpackage

// ---- rtl/bfs_supervisor.sv ----
// fault supervision and power-good sequencing for a buck converter
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
module bfs_supervisor #(
	parameter logic [bfs_pkg::TMR_W-1:0] PG_DELAY = 12'(bfs_pkg::PG_DELAY_US),
	parameter logic [bfs_pkg::TMR_W-1:0] PG_PROP = 12'(bfs_pkg::PG_PROP_US)
) (
	input wire logic clk,
	input wire logic reset_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	// host pins and analog comparator results, all asynchronous
	input wire logic enable_in,
	input wire logic [1:0] voltage_id_code,
	input wire logic bias_supply_monitor_in, // above start threshold
	input wire logic bias_hold_ok_in, // above start minus hysteresis
	input wire logic bias_por_ok_in, // above power-on-reset level
	input wire logic output_in_reg_in, // output reached regulation
	input wire logic soft_start_done_in, // soft-start ramp finished
	input wire logic ref_slewing_in, // voltage-id ramp in progress
	input wire logic output_overvoltage_trip, // above 120% reference
	input wire logic output_undervoltage_trip, // below 70% reference
	input wire logic over_current_limit, // positive valley limit
	input wire logic neg_over_current_limit, // negative valley limit
	input wire logic over_temp_in, // die hot
	input wire logic temp_cooled_in, // cooled by hysteresis
	input wire logic on_pulse_req_in, // on-time generator request
	// power stage and open-drain power-good
	output logic high_side_on,
	output logic low_side_on,
	output logic phase_hiz,
	output logic power_good_out,
	output logic power_good_oe_n
);
	// ****************************************
	// input synchronisers
	// ****************************************
	localparam int NS = 15; // synchronised inputs
	logic [NS-1:0] raw;
	logic [NS-1:0] meta_q; // first stage, read only by sync_q
	logic [NS-1:0] sync_q;
	assign raw = {voltage_id_code, bias_supply_monitor_in,
		bias_hold_ok_in, bias_por_ok_in, output_in_reg_in,
		soft_start_done_in, ref_slewing_in, output_overvoltage_trip,
		output_undervoltage_trip, over_current_limit,
		neg_over_current_limit, over_temp_in, temp_cooled_in,
		on_pulse_req_in};
	// two flops per pin; comparator outputs are not clock related
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= raw;
			sync_q <= meta_q;
		end
	end
	wire [1:0] vid_s = sync_q[14:13];
	wire bias_start_s = sync_q[12];
	wire bias_hold_s = sync_q[11];
	wire por_ok_s = sync_q[10];
	wire in_reg_s = sync_q[9];
	wire ss_done_s = sync_q[8];
	wire slewing_s = sync_q[7];
	wire ov_s = sync_q[6];
	wire uv_s = sync_q[5];
	wire ocl_s = sync_q[4];
	wire nocl_s = sync_q[3];
	wire hot_s = sync_q[2];
	wire cooled_s = sync_q[1];
	wire pulse_req_s = sync_q[0];
	logic en_meta_q; // first stage for the enable pin
	logic en_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			en_meta_q <= 1'b0;
			en_q <= 1'b0;
		end else begin
			en_meta_q <= enable_in;
			en_q <= en_meta_q;
		end
	end
	// ****************************************
	// microsecond tick
	// ****************************************
	logic [bfs_pkg::DIV_W-1:0] div_q;
	logic tick_q;
	wire div_wrap = (div_q == bfs_pkg::DIV_W'(bfs_pkg::TICK_CYC - 1));
	// one-cycle enable each microsecond feeds every delay timer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_q <= '0;
			tick_q <= 1'b0;
		end else begin
			div_q <= div_wrap ? '0 : div_q + 1'b1;
			tick_q <= div_wrap;
		end
	end
	// ****************************************
	// delay timers
	// ****************************************
	bfs_timer_if pg_dly_if ();
	bfs_timer_if pg_prop_if ();
	bfs_timer_if uv_dly_if ();
	bfs_delay_timer #(.LIMIT(PG_DELAY)) u_pg_dly (
		.clk(clk), .reset_n(reset_n), .tick(tick_q), .t(pg_dly_if));
	bfs_delay_timer #(.LIMIT(PG_PROP)) u_pg_prop (
		.clk(clk), .reset_n(reset_n), .tick(tick_q), .t(pg_prop_if));
	bfs_delay_timer #(.LIMIT(12'(bfs_pkg::UV_DELAY_US))) u_uv_dly (
		.clk(clk), .reset_n(reset_n), .tick(tick_q), .t(uv_dly_if));
	// ****************************************
	// registers
	// ****************************************
	logic [bfs_pkg::EV_W-1:0] status_q; // sticky events
	logic [bfs_pkg::EV_W-1:0] mask_q;
	logic [bfs_pkg::EV_W-1:0] ctrl_q;
	logic [bfs_pkg::EV_W-1:0] events; // one-cycle event pulses
	bfs_pkg::bfs_state_t state_q, state_d;
	logic pg_q;
	wire force_off = ctrl_q[bfs_pkg::CTRL_FORCE_OFF];
	// ****************************************
	// converter state machine
	// ****************************************
	wire run = (state_q == bfs_pkg::S_RUN);
	wire start_ok = en_q && bias_start_s && !hot_s && !force_off;
	wire lockout = !bias_hold_s;
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			bfs_pkg::S_OFF: begin
				if (start_ok) begin
					state_d = bfs_pkg::S_RUN;
				end
			end
			bfs_pkg::S_RUN: begin
				if (lockout) begin
					state_d = bfs_pkg::S_BIAS_UNDERVOLTAGE_LOCKOUT_LATCH;
				end else if (ov_s) begin
					state_d = bfs_pkg::S_OV_LATCH;
				end else if (hot_s) begin
					state_d = bfs_pkg::S_THERMAL;
				end else if (!en_q || force_off) begin
					state_d = bfs_pkg::S_OFF;
				end else if (uv_dly_if.done) begin
					state_d = bfs_pkg::S_UV_LATCH;
				end
			end
			bfs_pkg::S_THERMAL: begin
				// restart goes through off so start checks apply again
				if (cooled_s && !hot_s) begin
					state_d = bfs_pkg::S_OFF;
				end
			end
			bfs_pkg::S_UV_LATCH: begin
				if (!en_q) begin
					state_d = bfs_pkg::S_OFF;
				end
			end
			// enable is ignored here; only a bias reset leaves
			bfs_pkg::S_OV_LATCH: state_d = state_q;
			bfs_pkg::S_BIAS_UNDERVOLTAGE_LOCKOUT_LATCH: state_d = state_q;
			default: state_d = bfs_pkg::S_OFF;
		endcase
		// bias dropping to the reset level resets all latches
		if (!por_ok_s) begin
			state_d = bfs_pkg::S_OFF;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= bfs_pkg::S_OFF;
		end else begin
			state_q <= state_d;
		end
	end
	// ****************************************
	// undervoltage and power-good sequencing
	// ****************************************
	// undervoltage timer restarts whenever the output recovers
	assign uv_dly_if.run = run && uv_s;
	// regulation delay excludes the soft-start ramp
	assign pg_dly_if.run = run && in_reg_s && ss_done_s;
	assign pg_prop_if.run = pg_dly_if.run && pg_dly_if.done;
	// a ramping reference moves the window, so undervoltage is
	// blanked for power-good while slewing; overvoltage is not
	wire uv_fault = uv_s && !slewing_s;
	wire pg_drop = !en_q || lockout || ov_s || uv_fault || !run;
	wire pg_d = !pg_drop && (pg_q || pg_prop_if.done);
	// ****************************************
	// switch drive
	// ****************************************
	// the on-pulse is held off while the valley current is over the
	// limit and released when it drops, checked on every pulse
	wire hs_d = run && pulse_req_s && !ocl_s;
	// when sinking, the low side waits for the negative valley limit
	wire ls_d = run && !pulse_req_s && !nocl_s;
	// overvoltage protection keeps the low side on to pull down vout
	wire ovp_ls = (state_q == bfs_pkg::S_OV_LATCH);
	wire hiz_d = !(run || ovp_ls);
	logic hs_q, ls_q, hiz_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hs_q <= 1'b0;
			ls_q <= 1'b0;
			hiz_q <= 1'b1;
			pg_q <= 1'b0;
		end else begin
			hs_q <= hs_d && !lockout;
			ls_q <= (ls_d || ovp_ls) && !lockout;
			hiz_q <= hiz_d || lockout;
			pg_q <= pg_d;
		end
	end
	assign high_side_on = hs_q;
	assign low_side_on = ls_q;
	assign phase_hiz = hiz_q;
	// open drain: line released (enable high) while power is good
	assign power_good_out = 1'b0;
	assign power_good_oe_n = pg_q;
	// ****************************************
	// events and interrupt
	// ****************************************
	logic ocl_prev_q, nocl_prev_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ocl_prev_q <= 1'b0;
			nocl_prev_q <= 1'b0;
		end else begin
			ocl_prev_q <= ocl_s;
			nocl_prev_q <= nocl_s;
		end
	end
	wire entering = (state_d != state_q);
	assign events[bfs_pkg::EV_BIAS_UNDERVOLTAGE_LOCKOUT] = entering &&
		state_d == bfs_pkg::S_BIAS_UNDERVOLTAGE_LOCKOUT_LATCH;
	assign events[bfs_pkg::EV_OV] = entering &&
		state_d == bfs_pkg::S_OV_LATCH;
	assign events[bfs_pkg::EV_UV] = entering &&
		state_d == bfs_pkg::S_UV_LATCH;
	assign events[bfs_pkg::EV_OCL_POS] = ocl_s && !ocl_prev_q && run;
	assign events[bfs_pkg::EV_OCL_NEG] = nocl_s && !nocl_prev_q && run;
	assign events[bfs_pkg::EV_THERM] = entering &&
		state_d == bfs_pkg::S_THERMAL;
	assign events[bfs_pkg::EV_PG_RISE] = pg_d && !pg_q;
	assign events[bfs_pkg::EV_PG_FALL] = !pg_d && pg_q;
	// ****************************************
	// apb slave
	// ****************************************
	// setup cycle is decoded; access phase answers one cycle later
	wire setup = psel && !penable;
	wire access = psel && penable && pready;
	wire hit_status = (paddr == bfs_pkg::ADDR_STATUS);
	wire hit_mask = (paddr == bfs_pkg::ADDR_MASK);
	wire hit_state = (paddr == bfs_pkg::ADDR_STATE);
	wire hit_ctrl = (paddr == bfs_pkg::ADDR_CTRL);
	wire mapped = hit_status || hit_mask || hit_state || hit_ctrl;
	wire wr = access && pwrite && !pslverr;
	wire [bfs_pkg::EV_W-1:0] w1c = (wr && hit_status) ?
		pwdata[bfs_pkg::EV_W-1:0] : '0;
	wire [31:0] state_word = 32'(state_q) << bfs_pkg::ST_LSB |
		32'(pg_q) << bfs_pkg::PG_BIT | 32'(vid_s) << bfs_pkg::VID_LSB;
	wire [31:0] rd_mux = hit_status ? 32'(status_q) :
		hit_mask ? 32'(mask_q) :
		hit_ctrl ? 32'(ctrl_q) :
		hit_state ? state_word : 32'h0000_0000;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q, irq_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup && !mapped;
			prdata_q <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end
	// a new event wins over a clear in the same cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			status_q <= '0;
			mask_q <= bfs_pkg::MASK_RESET;
			ctrl_q <= bfs_pkg::CTRL_RESET;
			irq_q <= 1'b0;
		end else begin
			status_q <= (status_q & ~w1c) | events;
			if (wr && hit_mask) begin
				mask_q <= pwdata[bfs_pkg::EV_W-1:0];
			end
			if (wr && hit_ctrl) begin
				ctrl_q <= pwdata[bfs_pkg::EV_W-1:0];
			end
			irq_q <= |(((status_q & ~w1c) | events) & mask_q);
		end
	end
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;
endmodule

// ---- rtl/bfs_timer_if.sv ----
// request and status pair between the supervisor and a delay timer
`timescale 1ns/100ps
interface bfs_timer_if;
	logic run; // count while high, clear when low
	logic done; // delay has elapsed since run rose
	modport ctl (output run, input done);
	modport tmr (input run, output done);
endinterface

// ---- verification/bfs_host_model.sv ----
// host side model: drives enable and voltage id, reads power-good
`timescale 1ns/100ps
module bfs_host_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic en_req,
	input wire logic [1:0] vid_req,
	input wire logic power_good_out,
	input wire logic power_good_oe_n,
	output logic enable_in,
	output logic [1:0] voltage_id_code,
	output logic pg_pin
);
	// ****************************************
	// host pins
	// ****************************************
	// pins move just after an edge, as a synchronous sequencer would
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			enable_in <= 1'b0;
			voltage_id_code <= 2'h0;
		end else begin
			enable_in <= en_req;
			voltage_id_code <= vid_req;
		end
	end
	// board pull-up: a released open-drain pin reads high
	assign pg_pin = power_good_oe_n ? 1'b1 : power_good_out;
endmodule

// ---- verification/bfs_supervisor_asserts.sv ----
// port-level assertions for the fault supervisor
`timescale 1ns/100ps
module bfs_supervisor_asserts #(
	parameter logic [bfs_pkg::TMR_W-1:0] PG_DELAY = 12'h004,
	parameter logic [bfs_pkg::TMR_W-1:0] PG_PROP = 12'h002
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic enable_in,
	input wire logic bias_supply_monitor_in,
	input wire logic bias_hold_ok_in,
	input wire logic bias_por_ok_in,
	input wire logic output_in_reg_in,
	input wire logic soft_start_done_in,
	input wire logic output_overvoltage_trip,
	input wire logic over_current_limit,
	input wire logic over_temp_in,
	input wire logic high_side_on,
	input wire logic low_side_on,
	input wire logic phase_hiz,
	input wire logic power_good_out,
	input wire logic power_good_oe_n,
	input wire logic irq,
	input wire logic pslverr
);
	// ****************************************
	// helpers
	// ****************************************
	// tick phase is unknown, so allow two ticks of slack
	localparam int PG_MIN = (int'(PG_DELAY) + int'(PG_PROP) - 2) *
		bfs_pkg::TICK_CYC;
	int reg_cnt_q; // cycles in regulation with enable held
	wire in_reg_w = output_in_reg_in && soft_start_done_in && enable_in;
	wire start_ok_w = bias_supply_monitor_in && enable_in && !over_temp_in;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) reg_cnt_q <= 0;
		else if (in_reg_w) reg_cnt_q <= reg_cnt_q + 1;
		else reg_cnt_q <= 0;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ****************************************
	// assertions
	// ****************************************
	a_start_gated: assert property ($fell(phase_hiz) |->
		$past(start_ok_w, 3) || $past(start_ok_w, 4) || $past(start_ok_w, 5))
		else $error("switching began without start conditions");
	a_lockout_off: assert property (!bias_hold_ok_in [*6] |->
		!high_side_on && !power_good_oe_n)
		else $error("high side on or pg good in lockout");
	a_por_clears: assert property (!bias_por_ok_in [*6] |-> phase_hiz)
		else $error("phase not released under power-on reset");
	a_pg_delayed: assert property ($rose(power_good_oe_n) |->
		reg_cnt_q >= PG_MIN)
		else $error("power-good rose too early");
	a_enable_drops: assert property (!enable_in [*5] |->
		!power_good_oe_n)
		else $error("power-good held with enable low");
	a_pg_data_low: assert property (power_good_out == 1'b0)
		else $error("open-drain data not low");
	a_ov_drops_pg: assert property (output_overvoltage_trip [*5] |->
		!power_good_oe_n)
		else $error("power-good held in overvoltage");
	a_ocl_holds: assert property (over_current_limit [*5] |->
		!high_side_on)
		else $error("on-pulse issued above current limit");
	a_hot_off: assert property (over_temp_in [*6] |->
		!high_side_on && (phase_hiz || low_side_on))
		else $error("switching while hot");
	c_pg_rise: cover property ($rose(power_good_oe_n));
	c_irq: cover property ($rose(irq));
	c_slverr: cover property (pslverr);
endmodule
bind bfs_supervisor bfs_supervisor_asserts #(.PG_DELAY(PG_DELAY),
	.PG_PROP(PG_PROP)) i_bfs_supervisor_asserts (.clk, .reset_n,
	.enable_in, .bias_supply_monitor_in, .bias_hold_ok_in,
	.bias_por_ok_in, .output_in_reg_in, .soft_start_done_in,
	.output_overvoltage_trip, .over_current_limit, .over_temp_in,
	.high_side_on, .low_side_on, .phase_hiz, .power_good_out,
	.power_good_oe_n, .irq, .pslverr);

// ---- verification/bfs_supervisor_tb.sv ----
// self-checking bench for the fault supervisor
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin \
	fail_count++; $display("BAD %s exp %h got %h", nm, e, s); end end
module bfs_supervisor_tb;
	// ****************************************
	// stimulus and wiring
	// ****************************************
	logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd;
	logic err, en_req = 0;
	logic [1:0] vid_req = 2'h0;
	logic bias_supply_monitor_in = 1, bias_hold_ok_in = 1;
	logic bias_por_ok_in = 1, output_in_reg_in = 0, soft_start_done_in = 0;
	logic ref_slewing_in = 0, output_overvoltage_trip = 0;
	logic output_undervoltage_trip = 0, over_current_limit = 0;
	logic neg_over_current_limit = 0, over_temp_in = 0;
	logic temp_cooled_in = 1, on_pulse_req_in = 0;
	wire [31:0] prdata;
	wire [1:0] voltage_id_code;
	wire pready, pslverr, irq, enable_in, pg_pin, high_side_on;
	wire low_side_on, phase_hiz, power_good_out, power_good_oe_n;
	int fail_count = 0, n_checks = 0, cyc = 0;
	always #4 clk = ~clk; // 125 MHz
	// small delays keep the run short: 4 and 2 ticks
	bfs_supervisor #(.PG_DELAY(12'h004), .PG_PROP(12'h002)) i_bfs_supervisor (
		.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .irq, .enable_in, .voltage_id_code,
		.bias_supply_monitor_in, .bias_hold_ok_in, .bias_por_ok_in,
		.output_in_reg_in, .soft_start_done_in, .ref_slewing_in,
		.output_overvoltage_trip, .output_undervoltage_trip,
		.over_current_limit, .neg_over_current_limit, .over_temp_in,
		.temp_cooled_in, .on_pulse_req_in, .high_side_on, .low_side_on,
		.phase_hiz, .power_good_out, .power_good_oe_n);
	bfs_host_model i_bfs_host_model (.clk, .reset_n, .en_req, .vid_req,
		.power_good_out, .power_good_oe_n, .enable_in, .voltage_id_code,
		.pg_pin);
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one apb transfer; holds the request until pready is seen
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no local limit: only the bench timeout ends this wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// poll the live state until it matches or the budget runs out
	task automatic exp_st(input logic [2:0] e);
		int n;
		n = 0;
		do begin
			apb(1'b0, bfs_pkg::ADDR_STATE, 32'h0);
			n++;
		end while (rd[2:0] !== e && n < 500);
		`CHK("state", e, rd[2:0])
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs;
		apb(1'b0, bfs_pkg::ADDR_MASK, 32'h0);
		`CHK("mask reset", 32'h0, rd)
		apb(1'b0, bfs_pkg::ADDR_CTRL, 32'h0);
		`CHK("ctrl reset", 32'h0, rd)
		apb(1'b0, 8'h10, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		apb(1'b1, bfs_pkg::ADDR_MASK, 32'h1ff);
		apb(1'b0, bfs_pkg::ADDR_MASK, 32'h0);
		`CHK("mask width", 32'hff, rd)
		apb(1'b1, bfs_pkg::ADDR_MASK, 32'h40);
		$display("done t_regs");
	endtask
	task automatic t_start;
		bias_supply_monitor_in <= 1'b0;
		en_req <= 1'b1;
		w(30);
		exp_st(bfs_pkg::S_OFF);
		bias_supply_monitor_in <= 1'b1;
		on_pulse_req_in <= 1'b1;
		exp_st(bfs_pkg::S_RUN);
		w(6);
		`CHK("hs on", 1'b1, high_side_on)
		output_in_reg_in <= 1'b1;
		soft_start_done_in <= 1'b1;
		w(450);
		`CHK("pg early", 1'b0, pg_pin)
		for (int n = 0; n < 400 && pg_pin !== 1'b1; n++) w(1);
		`CHK("pg late", 1'b1, pg_pin)
		w(2);
		`CHK("irq set", 1'b1, irq)
		apb(1'b0, bfs_pkg::ADDR_STATUS, 32'h0);
		`CHK("status pg rise", 32'h40, rd)
		apb(1'b1, bfs_pkg::ADDR_STATUS, 32'hff);
		w(2);
		`CHK("irq clr", 1'b0, irq)
		apb(1'b0, bfs_pkg::ADDR_STATUS, 32'h0);
		`CHK("status clr", 32'h0, rd)
		$display("done t_start");
	endtask
	task automatic t_ocl;
		over_current_limit <= 1'b1;
		w(6);
		`CHK("ocl hold", 1'b0, high_side_on)
		over_current_limit <= 1'b0;
		w(6);
		`CHK("ocl release", 1'b1, high_side_on)
		on_pulse_req_in <= 1'b0;
		neg_over_current_limit <= 1'b1;
		w(6);
		`CHK("neg hold", 1'b0, low_side_on)
		neg_over_current_limit <= 1'b0;
		w(6);
		`CHK("neg release", 1'b1, low_side_on)
		$display("done t_ocl");
	endtask
	task automatic t_uv;
		ref_slewing_in <= 1'b1;
		vid_req <= 2'h1;
		output_undervoltage_trip <= 1'b1;
		w(40);
		`CHK("pg blanked", 1'b1, pg_pin)
		output_undervoltage_trip <= 1'b0;
		ref_slewing_in <= 1'b0;
		w(6);
		output_undervoltage_trip <= 1'b1;
		w(8);
		`CHK("pg uv", 1'b0, pg_pin)
		exp_st(bfs_pkg::S_UV_LATCH);
		`CHK("uv hiz", 1'b1, phase_hiz)
		output_undervoltage_trip <= 1'b0;
		w(50);
		exp_st(bfs_pkg::S_UV_LATCH);
		en_req <= 1'b0;
		w(10);
		en_req <= 1'b1;
		exp_st(bfs_pkg::S_RUN);
		$display("done t_uv");
	endtask
	task automatic t_ov;
		output_overvoltage_trip <= 1'b1;
		w(6);
		`CHK("pg ov", 1'b0, pg_pin)
		exp_st(bfs_pkg::S_OV_LATCH);
		`CHK("ov low side", 1'b1, low_side_on)
		output_overvoltage_trip <= 1'b0;
		en_req <= 1'b0;
		w(10);
		en_req <= 1'b1;
		w(10);
		exp_st(bfs_pkg::S_OV_LATCH);
		bias_por_ok_in <= 1'b0;
		w(6);
		bias_por_ok_in <= 1'b1;
		exp_st(bfs_pkg::S_RUN);
		$display("done t_ov");
	endtask
	task automatic t_bias_undervoltage_lockout;
		bias_hold_ok_in <= 1'b0;
		bias_supply_monitor_in <= 1'b0;
		w(6);
		`CHK("pg bias_undervoltage_lockout", 1'b0, pg_pin)
		exp_st(bfs_pkg::S_BIAS_UNDERVOLTAGE_LOCKOUT_LATCH);
		`CHK("bias_undervoltage_lockout hiz", 3'h4, {phase_hiz, high_side_on, low_side_on})
		bias_hold_ok_in <= 1'b1;
		bias_supply_monitor_in <= 1'b1;
		w(20);
		exp_st(bfs_pkg::S_BIAS_UNDERVOLTAGE_LOCKOUT_LATCH);
		bias_por_ok_in <= 1'b0;
		w(6);
		bias_por_ok_in <= 1'b1;
		exp_st(bfs_pkg::S_RUN);
		// software force-off must stop and then allow a restart
		apb(1'b1, bfs_pkg::ADDR_CTRL, 32'h1);
		exp_st(bfs_pkg::S_OFF);
		apb(1'b1, bfs_pkg::ADDR_CTRL, 32'h0);
		exp_st(bfs_pkg::S_RUN);
		$display("done t_bias_undervoltage_lockout");
	endtask
	task automatic t_therm;
		over_temp_in <= 1'b1;
		temp_cooled_in <= 1'b0;
		exp_st(bfs_pkg::S_THERMAL);
		`CHK("hot hiz", 1'b1, phase_hiz)
		over_temp_in <= 1'b0;
		temp_cooled_in <= 1'b1;
		exp_st(bfs_pkg::S_RUN);
		for (int n = 0; n < 900 && pg_pin !== 1'b1; n++) w(1);
		`CHK("pg restart", 1'b1, pg_pin)
		// run state, power-good bit and voltage id 1 from t_uv
		apb(1'b0, bfs_pkg::ADDR_STATE, 32'h0);
		`CHK("state word", 32'h111, rd)
		en_req <= 1'b0;
		w(5);
		`CHK("pg enable", 1'b0, pg_pin)
		$display("done t_therm");
	endtask
	// ****************************************
	// run control
	// ****************************************
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// hang guard: the whole sequence needs well under this
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			complete_run();
		end
	end
	initial begin
		w(12);
		reset_n <= 1'b1;
		t_regs();
		t_start();
		t_ocl();
		t_uv();
		t_ov();
		t_bias_undervoltage_lockout();
		t_therm();
		complete_run();
	end
endmodule
